// ### hw/digipot_cfg.svh
// Constants of the quad digital potentiometer command decoder.
`ifndef DIGIPOT_CFG_SVH
`define DIGIPOT_CFG_SVH

// =============================================================
// Frame layout
`define FRAME_BITS 24
`define CNT_W 5
`define CHANNELS 4
`define SLOTS 4
`define TAP_W 8
`define WORD_W 9

// =============================================================
// Opcodes
`define OP_NOP 4'h0
`define OP_WAKE 4'h1
`define OP_PROG 4'h2
`define OP_STORE 4'h3
`define OP_WRITE 4'h4
`define OP_UP 4'h7
`define OP_SLEEP 4'h8
`define OP_RESET 4'h9
`define OP_READ_NV 4'ha
`define OP_LOAD 4'hb
`define OP_READ_TAP 4'hc
`define OP_ERASE 4'hd
`define OP_DOWN 4'hf

// =============================================================
// Reset and storage values
`define NV_INIT_WORD 9'h080
`define ERASED_WORD 9'h000
`define TAP_MAX 8'hff
`define TAP_MIN 8'h00

// =============================================================
// Timing
`define CLK_PERIOD_NS 8
`define T_SAVE_NS 2000000
`define NV_CYCLES (`T_SAVE_NS / `CLK_PERIOD_NS)
`define READ_PREP_CYCLES 4
`define BUSY_W 18

`endif

// ### hw/digipot_pkg.sv
// Types shared by the potentiometer command decoder.
package digipot_pkg;

  typedef struct packed {
    logic [3:0] opcode_bits;
    logic [1:0] slot_select_bits;
    logic [1:0] channel_select_bits;
    logic [6:0] unused_bits;
    logic buffer_mode_bit;
    logic [7:0] tap_value_bits;
  } cmd_type;

  typedef logic [3:0][7:0] tap_bus_type;

  typedef enum logic {ST_READY, ST_BUSY} ctl_state_type;

endpackage

// ### hw/pin_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] init_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // The first stage feeds the second stage only.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ### hw/digipot_cmd_decoder.sv
// Command decoder of the quad 256-tap digital potentiometer.
// Operation
// - A command is 24 clocks: opcode, slot and channel bits, two data bytes.
// - Commands act only when framed by chip select low then high.
// - Input sampled on rising clock; output changes on falling clock or select.
// - Opcode 0000 changes nothing.
// - Opcode 0100 writes the data byte into the chosen wiper.
// - Opcode 0111 steps the chosen wiper up by one.
// - Opcode 1111 steps the chosen wiper down by one.
// - Opcode 1011 loads wiper and buffer mode from the addressed slot.
// - Opcode 1100 selects wiper and buffer mode for readback.
// - Opcode 1010 selects the addressed slot for readback.
// - Each slot holds nine bits: tap value plus buffer mode.
// - Opcode 1101 erases the addressed slot.
// - Opcode 0010 programs the addressed slot with the nine data bits.
// - Opcode 0011 saves the wiper and buffer mode into the slot.
// - Buffer mode changes only through a slot load.
// - Opcode 1000 puts the whole device to sleep.
// - Opcode 0001 wakes the device.
// - Opcode 1001 returns the device to its power-up state.
// - Device sleeps after power-up, soft reset and sleep command.
// - Asleep, wipers are kept and only wake is obeyed.
// - Channel and slot select bits decode in binary order.
// - Steps saturate at both ends of the tap range.
// - Power-up and soft reset load each wiper from its slot 0.
// - A read's value shifts out during the next command.
`include "digipot_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module digipot_cmd_decoder #(
  parameter int NV_CYCLES = `NV_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SDI_I,
  input wire logic WP_N_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  output logic RDY_O,
  output logic SLEEP_O,
  output digipot_pkg::tap_bus_type WIPER_O,
  output logic [3:0] BUF_MODE_O
);
  import digipot_pkg::*;

  // =============================================================
  // Decode helpers
  function automatic logic is_nv_write(input logic [3:0] op);
    is_nv_write = (op == `OP_PROG) || (op == `OP_STORE) || (op == `OP_ERASE);
  endfunction

  function automatic logic needs_wait(input logic [3:0] op);
    needs_wait = is_nv_write(op) || (op == `OP_READ_TAP) || (op == `OP_READ_NV) || (op == `OP_LOAD);
  endfunction

  // =============================================================
  // Pin synchronisation and edge detection
  logic [3:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic wp_n_s;
  logic sclk_q_r;
  logic cs_n_q_r;

  pin_sync #(.W(4)) u_sync (
    .REF_CLK_I(REF_CLK_I),
    .NRST_I(NRST_I),
    .async_i({SCLK_I, CS_N_I, SDI_I, WP_N_I}),
    .init_i(4'hf),
    .sync_o(pins_s)
  );

  assign {sclk_s, cs_n_s, sdi_s, wp_n_s} = pins_s;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sclk_q_r <= 1'b0;
      cs_n_q_r <= 1'b1;
    end else begin
      sclk_q_r <= sclk_s;
      cs_n_q_r <= cs_n_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = sclk_s && !sclk_q_r && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_q_r && !cs_n_s;
  assign cs_fall = !cs_n_s && cs_n_q_r;
  assign cs_rise = cs_n_s && !cs_n_q_r;

  // =============================================================
  // Frame capture
  cmd_type cmd_r;
  logic [`CNT_W-1:0] bit_cnt_r;
  logic exec;
  logic exec_ok;
  logic sleep_r;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cmd_r <= '0;
      bit_cnt_r <= '0;
    end else if (cs_fall) begin
      bit_cnt_r <= '0;
    end else if (sclk_rise) begin
      cmd_r <= {cmd_r[`FRAME_BITS-2:0], sdi_s};
      if (bit_cnt_r != '1) begin
        bit_cnt_r <= bit_cnt_r + `CNT_W'(1);
      end
    end
  end

  // A frame with any count other than 24 is dropped whole.
  assign exec = cs_rise && (bit_cnt_r == `CNT_W'(`FRAME_BITS));
  // Asleep, only the wake opcode gets through.
  assign exec_ok = exec && !sleep_r;

  logic [3:0] op;
  logic [1:0] ch;
  logic [1:0] sl;
  logic do_reset;
  logic nv_wr_ok;
  assign op = cmd_r.opcode_bits;
  assign ch = cmd_r.channel_select_bits;
  assign sl = cmd_r.slot_select_bits;
  assign do_reset = exec_ok && (op == `OP_RESET);
  // Slot writes (program, store, erase) are blocked while the write-protect pin is low; wiper writes are not.
  assign nv_wr_ok = exec_ok && wp_n_s && is_nv_write(op);

  // =============================================================
  // Power state
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sleep_r <= 1'b1;
    end else if (exec && sleep_r && (op == `OP_WAKE)) begin
      sleep_r <= 1'b0;
    end else if (exec_ok && ((op == `OP_SLEEP) || (op == `OP_RESET))) begin
      sleep_r <= 1'b1;
    end
  end

  // =============================================================
  // Persistent slots and wipers
  logic [`WORD_W-1:0] nv_r [`CHANNELS][`SLOTS];
  logic [`TAP_W-1:0] wiper_r [`CHANNELS];
  // One flip-flop per channel, so that each channel's process owns its own mode bit.
  logic mode_r [`CHANNELS];

  for (genvar c = 0; c < `CHANNELS; c++) begin : g_chan
    for (genvar s = 0; s < `SLOTS; s++) begin : g_slot
      always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          nv_r[c][s] <= `NV_INIT_WORD;
        end else if (nv_wr_ok && (ch == 2'(c)) && (sl == 2'(s))) begin
          case (op)
            `OP_ERASE: nv_r[c][s] <= `ERASED_WORD;
            `OP_PROG: nv_r[c][s] <= {cmd_r.buffer_mode_bit, cmd_r.tap_value_bits};
            `OP_STORE: nv_r[c][s] <= {mode_r[c], wiper_r[c]};
            default: nv_r[c][s] <= nv_r[c][s];
          endcase
        end
      end
    end

    // Power-up value equals the slot 0 reset word.
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        wiper_r[c] <= `TAP_W'(`NV_INIT_WORD);
        mode_r[c] <= 1'(`NV_INIT_WORD >> `TAP_W);
      end else if (do_reset) begin
        {mode_r[c], wiper_r[c]} <= nv_r[c][0];
      end else if (exec_ok && (ch == 2'(c))) begin
        // Only the load path touches the buffer mode.
        case (op)
          `OP_WRITE: wiper_r[c] <= cmd_r.tap_value_bits;
          `OP_UP: begin
            if (wiper_r[c] != `TAP_MAX) begin
              wiper_r[c] <= wiper_r[c] + `TAP_W'(1);
            end
          end
          `OP_DOWN: begin
            if (wiper_r[c] != `TAP_MIN) begin
              wiper_r[c] <= wiper_r[c] - `TAP_W'(1);
            end
          end
          `OP_LOAD: {mode_r[c], wiper_r[c]} <= nv_r[c][sl];
          default: wiper_r[c] <= wiper_r[c];
        endcase
      end
    end

    assign WIPER_O[c] = wiper_r[c];
    assign BUF_MODE_O[c] = mode_r[c];
  end

  assign SLEEP_O = sleep_r;

  // =============================================================
  // Readback selection and serial output
  logic [`WORD_W-1:0] rd_word_r;
  logic [`FRAME_BITS-1:0] out_sh_r;
  logic sdo_r;
  logic sdo_oe_r;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_word_r <= '0;
    end else if (do_reset) begin
      rd_word_r <= '0;
    end else if (exec_ok && (op == `OP_READ_TAP)) begin
      rd_word_r <= {mode_r[ch], wiper_r[ch]};
    end else if (exec_ok && (op == `OP_READ_NV)) begin
      rd_word_r <= nv_r[ch][sl];
    end
  end

  // The selected word is loaded at the next frame's start.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      out_sh_r <= '0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_oe_r <= !cs_n_s;
      if (cs_fall) begin
        out_sh_r <= {(`FRAME_BITS - `WORD_W)'(0), rd_word_r};
        sdo_r <= 1'b0;
      end else if (sclk_fall) begin
        out_sh_r <= {out_sh_r[`FRAME_BITS-2:0], 1'b0};
        sdo_r <= out_sh_r[`FRAME_BITS-2];
      end
    end
  end

  assign SDO_O = sdo_r;
  assign SDO_OE_O = sdo_oe_r;

  // =============================================================
  // Ready/busy pacing
  // The slot cycle is modelled as a fixed wait; the data is already
  // stored, so only the pacing of the host is affected.
  ctl_state_type state_r;
  logic [`BUSY_W-1:0] busy_cnt_r;
  logic rdy_r;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= ST_READY;
      busy_cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      case (state_r)
        ST_READY: begin
          if (exec_ok && needs_wait(op)) begin
            state_r <= ST_BUSY;
            rdy_r <= 1'b0;
            if (is_nv_write(op)) begin
              busy_cnt_r <= `BUSY_W'(NV_CYCLES - 1);
            end else begin
              busy_cnt_r <= `BUSY_W'(`READ_PREP_CYCLES - 1);
            end
          end
        end
        ST_BUSY: begin
          if (busy_cnt_r == '0) begin
            state_r <= ST_READY;
            rdy_r <= 1'b1;
          end else begin
            busy_cnt_r <= busy_cnt_r - `BUSY_W'(1);
          end
        end
        default: begin
          state_r <= ST_READY;
          rdy_r <= 1'b1;
        end
      endcase
    end
  end

  assign RDY_O = rdy_r;

  // =============================================================
  // Checks
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_awake_cmd(logic [3:0] code);
    exec && !sleep_r && (op == code);
  endsequence

  sequence s_wait_cmd;
    exec && !sleep_r && needs_wait(op);
  endsequence

  nop_no_change_a: assert property (s_awake_cmd(`OP_NOP) |=>
      $stable(BUF_MODE_O) && $stable(WIPER_O) && $stable(sleep_r) && $stable(rd_word_r))
    else $error("No-operation changed state.");

  write_tap_a: assert property (s_awake_cmd(`OP_WRITE) |=> wiper_r[ch] == cmd_r.tap_value_bits)
    else $error("Tap write did not land.");

  step_up_a: assert property (s_awake_cmd(`OP_UP) |=>
      wiper_r[ch] == (($past(wiper_r[ch]) == `TAP_MAX) ? `TAP_MAX : $past(wiper_r[ch]) + `TAP_W'(1)))
    else $error("Up step wrong.");

  step_down_a: assert property (s_awake_cmd(`OP_DOWN) |=>
      wiper_r[ch] == (($past(wiper_r[ch]) == `TAP_MIN) ? `TAP_MIN : $past(wiper_r[ch]) - `TAP_W'(1)))
    else $error("Down step wrong.");

  mode_hold_a: assert property ((s_awake_cmd(`OP_WRITE) or s_awake_cmd(`OP_UP) or s_awake_cmd(`OP_DOWN))
      |=> $stable(BUF_MODE_O))
    else $error("Buffer mode moved without a load.");

  slot_load_a: assert property (s_awake_cmd(`OP_LOAD) |=> {mode_r[ch], wiper_r[ch]} == $past(nv_r[ch][sl]))
    else $error("Slot load wrong.");

  sleep_ignore_a: assert property (exec && sleep_r && (op != `OP_WAKE) |=>
      $stable(BUF_MODE_O) && $stable(WIPER_O) && sleep_r)
    else $error("Command obeyed while asleep.");

  sleep_enter_a: assert property (s_awake_cmd(`OP_SLEEP) |=> sleep_r)
    else $error("Sleep not entered.");

  wake_a: assert property (exec && sleep_r && (op == `OP_WAKE) |=> !sleep_r)
    else $error("Wake not taken.");

  busy_low_a: assert property (s_wait_cmd |=> !RDY_O ##1 !RDY_O)
    else $error("Ready not lowered for a slow command.");

  read_busy_end_a: assert property (s_awake_cmd(`OP_READ_TAP) |=> !RDY_O [*4] ##1 RDY_O)
    else $error("Read preparation time wrong.");

  oe_frame_a: assert property (cs_fall |=> SDO_OE_O && !SDO_O)
    else $error("Output not driven at frame start.");

endmodule

`default_nettype wire

// ### sim/spi_host_model.sv
// Host side of the serial command link: frames commands and gathers readback bits.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  input wire logic REF_CLK_I,
  input wire logic SDO_I,
  input wire logic SDO_OE_I,
  output logic SCLK_O,
  output logic CS_N_O,
  output logic SDI_O
);
  initial begin
    SCLK_O = 1'b0;
    CS_N_O = 1'b1;
    SDI_O = 1'b0;
  end

  // =============================================================
  // Framing
  // Four reference clocks per phase gives the 64 ns link period.
  task automatic half();
    repeat (4) @(negedge REF_CLK_I);
  endtask

  // Output bits are taken mid-high phase, well clear of the synchronised falling edge.
  task automatic frame(input logic [23:0] word, input int nbits, output logic [23:0] rx, output logic oe);
    rx = '0;
    oe = 1'b1;
    CS_N_O = 1'b0;
    half();
    for (int i = 0; i < nbits; i++) begin
      SDI_O = word[23-i];
      half();
      SCLK_O = 1'b1;
      repeat (2) @(negedge REF_CLK_I);
      rx[23-i] = SDO_I;
      oe = oe & SDO_OE_I;
      repeat (2) @(negedge REF_CLK_I);
      SCLK_O = 1'b0;
    end
    half();
    CS_N_O = 1'b1;
    // The data line no longer holds the last bit once the frame is over.
    SDI_O = ~SDI_O;
  endtask
endmodule
`default_nettype wire

// ### sim/quad_digipot_spi_command_decoder_tb.sv
// Self-checking bench for the potentiometer command decoder.
`include "digipot_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module quad_digipot_spi_command_decoder_tb;
  import digipot_pkg::*;
  localparam int NV = 20;
  logic clk, nrst, sclk, cs_n, sdi, wp_n, sdo, sdo_oe, rdy, sleep;
  tap_bus_type wiper;
  logic [3:0] bmode;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] m_tap [4];
  logic [3:0] m_mode;
  logic [8:0] m_nv [4][4];
  logic m_sleep, last_read;
  logic [8:0] m_rb;
  localparam logic [23:0] CORNER [16] = '{24'h42_0055, 24'h10_0000, 24'h42_00ff, 24'h72_0000,
    24'h40_0000, 24'hf0_0000, 24'hd5_0000, 24'h25_01aa, 24'hb5_0000, 24'hc1_0000,
    24'ha5_0000, 24'h00_0000, 24'h80_0000, 24'h40_0033, 24'h90_0000, 24'h10_0000};

  digipot_cmd_decoder #(.NV_CYCLES(NV)) u_dut (.REF_CLK_I(clk), .NRST_I(nrst), .SCLK_I(sclk),
    .CS_N_I(cs_n), .SDI_I(sdi), .WP_N_I(wp_n), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .RDY_O(rdy),
    .SLEEP_O(sleep), .WIPER_O(wiper), .BUF_MODE_O(bmode));
  spi_host_model u_host (.REF_CLK_I(clk), .SDO_I(sdo), .SDO_OE_I(sdo_oe), .SCLK_O(sclk),
    .CS_N_O(cs_n), .SDI_O(sdi));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // =============================================================
  // Checking and reference model
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic model_reset(input logic power);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 4 && power; s++) m_nv[c][s] = `NV_INIT_WORD;
      {m_mode[c], m_tap[c]} = m_nv[c][0];
    end
    m_sleep = 1'b1;
  endtask

  task automatic predict(input cmd_type c);
    int ch;
    int sl;
    ch = c.channel_select_bits;
    sl = c.slot_select_bits;
    if (m_sleep && c.opcode_bits != `OP_WAKE) return;
    case (c.opcode_bits)
      `OP_WAKE: m_sleep = 1'b0;
      `OP_SLEEP: m_sleep = 1'b1;
      `OP_RESET: model_reset(1'b0);
      `OP_WRITE: m_tap[ch] = c.tap_value_bits;
      `OP_UP: if (m_tap[ch] != `TAP_MAX) m_tap[ch]++;
      `OP_DOWN: if (m_tap[ch] != `TAP_MIN) m_tap[ch]--;
      `OP_LOAD: {m_mode[ch], m_tap[ch]} = m_nv[ch][sl];
      `OP_READ_TAP: m_rb = {m_mode[ch], m_tap[ch]};
      `OP_READ_NV: m_rb = m_nv[ch][sl];
      `OP_ERASE: if (wp_n) m_nv[ch][sl] = `ERASED_WORD;
      `OP_PROG: if (wp_n) m_nv[ch][sl] = {c.buffer_mode_bit, c.tap_value_bits};
      `OP_STORE: if (wp_n) m_nv[ch][sl] = {m_mode[ch], m_tap[ch]};
      default: ;
    endcase
    last_read = c.opcode_bits inside {`OP_READ_TAP, `OP_READ_NV};
  endtask

  task automatic wait_ready();
    int k;
    for (k = 0; k < 400 && rdy !== 1'b1; k++) @(negedge clk);
    if (k == 400) begin
      failures++;
      final_report();
    end
  endtask

  // =============================================================
  // One command: frame, expectations, settled outputs
  task automatic run_cmd(input logic [23:0] word, input int nbits);
    logic [23:0] rx;
    logic oe;
    logic slow;
    wait_ready();
    u_host.frame(word, nbits, rx, oe);
    check("output enable", 32'(oe), 32'h1);
    if (last_read) check("readback", 32'(rx), {23'h0, m_rb});
    last_read = 1'b0;
    slow = !m_sleep && nbits == 24 && word[23:20] inside {`OP_PROG, `OP_STORE, `OP_ERASE};
    if (nbits == 24) predict(cmd_type'(word));
    repeat (8) @(negedge clk);
    if (slow) check("ready", 32'(rdy), 32'h0);
    wait_ready();
    check("sleep", 32'(sleep), 32'(m_sleep));
    check("wipers", wiper, {m_tap[3], m_tap[2], m_tap[1], m_tap[0]});
    check("buffer mode", 32'(bmode), 32'(m_mode));
    check("idle enable", 32'(sdo_oe), 32'h0);
  endtask

  // =============================================================
  // Main sequence
  initial begin
    logic [23:0] w;
    nrst = 1'b0;
    wp_n = 1'b1;
    last_read = 1'b0;
    m_rb = '0;
    model_reset(1'b1);
    w = $urandom(8);
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check("ready", 32'(rdy), 32'h1);
    for (int i = 0; i < 16; i++) begin
      run_cmd(CORNER[i], 24);
      if (i == 2) run_cmd(24'h43_00aa, 23);
    end
    wp_n = 1'b0;
    run_cmd(24'hd0_0000, 24);
    run_cmd(24'h20_01ff, 24);
    for (int i = 0; i < 250; i++) begin
      w = $urandom;
      wp_n = ($urandom % 8) != 0;
      if (m_sleep && w[0]) w[23:20] = `OP_WAKE;
      if (last_read) w[23:20] = w[1] ? `OP_READ_TAP : (w[2] ? `OP_READ_NV : `OP_NOP);
      if (w[23:20] == `OP_PROG) run_cmd({`OP_ERASE, w[19:0]}, 24);
      run_cmd(w, 24);
    end
    final_report();
  end
endmodule
`default_nettype wire
